// File: core/rsc_top.sv
// reset source controller with an AXI4-Lite register slave
// Behaviour
// - only 55h/aah guard values are harmless
// - guard key powers up as 55h
// - guard fault sets cause bit 3
// - resets restore guard except warm reset
// - flags set by hardware, cleared by software
// - enabled brownout resets and sets bit 2
// - short low-voltage pulses are ignored
// - filter select picks 8/32/64/128 periods
// - threshold codes choose level or disable
// - bad threshold code resets, flags, reloads
// - genuine brownout keeps threshold register
// - brownout disabled in sleep mode
// - writing 55h to flash control resets
// - run-mode watchdog timeout acts like brownout
// - sleep timeout: pc/sp only, TO POWERDOWN_STATUS_FLAG set
// - power-on clears TO POWERDOWN_STATUS_FLAG; brownout keeps
// - power-on does full chip initialisation
// - bad watchdog key resets, sets bit 0
`timescale 1ns/1ps
module rsc_top
	import rsc_pkg::*;
#(
	parameter int SRESET_CYC = RSC_SRESET_CYC
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic por_event,
	input wire logic low_voltage,
	input wire logic low_speed_oscillator_tick,
	input wire logic wdt_timeout,
	input wire logic [31:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [31:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	output rsc_req_s chip_reset,
	output logic lvr_active
);
	// the delay counter is 16 bits wide and needs at least one cycle
	if (SRESET_CYC < 1 || SRESET_CYC > 65535)
	begin : g_bad_delay
		$error("SRESET_CYC out of range");
	end

	// decode used by the threshold fault check and the brownout enable
	function automatic logic valid_thresh(input logic [7:0] c);
		valid_thresh = (c == RSC_TH_1V70) || (c == RSC_TH_1V90) || (c == RSC_TH_2V55) ||
			(c == RSC_TH_3V15) || (c == RSC_TH_3V80) || (c == RSC_TH_OFF);
	endfunction

	logic [7:0] guard_r;
	logic [7:0] thresh_r;
	logic [1:0] filt_r;
	logic [4:0] wdkey_r;
	logic [3:0] cause_r;
	logic to_r;
	logic pdf_r;
	logic sleep_r;
	logic [7:0] lv_cnt_r;
	logic [15:0] dly_r;
	rsc_state_e st_r;
	logic [2:0] pend_r;
	logic flash_req;
	logic full_rst;
	logic warm_rst;
	logic guard_bad;
	logic thresh_bad;
	logic wdkey_bad;
	logic soft_bad;
	logic lvr_en;
	logic brown_fire;
	logic [7:0] fw;
	logic aw_hold_r;
	logic w_hold_r;
	logic [7:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic wr_go;
	logic [7:0] ra;

	// key checks
	assign guard_bad = (guard_r != RSC_GUARD_POR) && (guard_r != RSC_GUARD_ALT);
	assign thresh_bad = !valid_thresh(thresh_r);
	assign wdkey_bad = (wdkey_r != RSC_WDKEY_POR) && (wdkey_r != RSC_WDKEY_OFF);
	assign soft_bad = guard_bad | thresh_bad | wdkey_bad;
	assign lvr_en = (thresh_r != RSC_TH_OFF) && !thresh_bad && !sleep_r;
	assign lvr_active = lvr_en;

	// filter width select
	always_comb
	begin
		unique case (filt_r)
			2'b00: fw = RSC_FW0;
			2'b01: fw = RSC_FW1;
			2'b10: fw = RSC_FW2;
			2'b11: fw = RSC_FW3;
		endcase
	end

	// low-voltage filter: counts oscillator ticks while the condition holds
	always_ff @(posedge aclk)
	begin
		if (!aresetn || por_event || !low_voltage || !lvr_en || full_rst)
			lv_cnt_r <= 8'h00;
		else if (low_speed_oscillator_tick && lv_cnt_r < fw)
			lv_cnt_r <= lv_cnt_r + 8'h01;
	end
	// tick alignment makes the width land between fw-1 and fw periods
	// a shorter width picked mid-count fires at once instead of wrapping
	assign brown_fire = (lv_cnt_r >= fw) && low_voltage && lvr_en;

	// soft reset delay sequencer; pending causes latched at detection
	always_ff @(posedge aclk)
	begin
		if (!aresetn || por_event || full_rst)
		begin
			st_r <= RSC_RUN;
			dly_r <= 16'h0000;
			pend_r <= 3'b000;
		end
		else
		begin
			unique case (st_r)
				RSC_RUN:
				if (soft_bad)
				begin
					st_r <= RSC_DELAY;
					dly_r <= 16'h0000;
					pend_r <= {guard_bad, thresh_bad, wdkey_bad};
				end
				RSC_DELAY:
				if (dly_r == 16'(SRESET_CYC - 1))
					st_r <= RSC_FIRE;
				else
					dly_r <= dly_r + 16'h0001;
				RSC_FIRE:
					st_r <= RSC_RUN;
				default:
					st_r <= RSC_RUN;
			endcase
		end
	end

	assign full_rst = (st_r == RSC_FIRE) || flash_req || brown_fire || (wdt_timeout && !sleep_r);
	assign warm_rst = wdt_timeout && sleep_r && !full_rst;

	// reset request outputs, registered
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			chip_reset <= '0;
		else
		begin
			chip_reset.full <= full_rst | por_event;
			chip_reset.warm <= warm_rst;
		end
	end

	// axi write capture
	assign s_awready = !aw_hold_r;
	assign s_wready = !w_hold_r;
	assign wr_go = aw_hold_r && w_hold_r && !s_bvalid;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r <= 32'h0;
			w_strb_r <= 4'h0;
			s_bvalid <= 1'b0;
			s_bresp <= RSC_RESP_OKAY;
		end
		else
		begin
			if (s_awvalid && s_awready)
			begin
				aw_hold_r <= 1'b1;
				aw_addr_r <= s_awaddr[7:0];
			end
			if (s_wvalid && s_wready)
			begin
				w_hold_r <= 1'b1;
				w_data_r <= s_wdata;
				w_strb_r <= s_wstrb;
			end
			if (wr_go)
			begin
				aw_hold_r <= 1'b0;
				w_hold_r <= 1'b0;
				s_bvalid <= 1'b1;
				s_bresp <= (aw_addr_r > RSC_OFF_CTRL || aw_addr_r[1:0] != 2'b00) ? RSC_RESP_SLVERR : RSC_RESP_OKAY;
			end
			else if (s_bvalid && s_bready)
				s_bvalid <= 1'b0;
		end
	end

	logic wr_lane;
	assign wr_lane = wr_go && w_strb_r[0];
	assign flash_req = wr_lane && aw_addr_r == RSC_OFF_FLASH1 && w_data_r[7:0] == RSC_FLASH_RST;

	// key and configuration registers; reset kinds restore as documented
	always_ff @(posedge aclk)
	begin
		if (!aresetn || por_event)
		begin
			guard_r <= RSC_GUARD_POR;
			thresh_r <= RSC_THRESH_POR;
			filt_r <= RSC_FILT_POR;
			wdkey_r <= RSC_WDKEY_POR;
		end
		else if (full_rst)
		begin
			guard_r <= RSC_GUARD_POR;
			filt_r <= RSC_FILT_POR;
			wdkey_r <= RSC_WDKEY_POR;
			// genuine brownout leaves the threshold alone
			if (thresh_bad)
				thresh_r <= RSC_THRESH_POR;
		end
		else if (wr_lane)
		begin
			// warm reset does not touch these
			unique case (aw_addr_r)
				RSC_OFF_GUARD: guard_r <= w_data_r[7:0];
				RSC_OFF_THRESH: thresh_r <= w_data_r[7:0];
				RSC_OFF_FILT: filt_r <= w_data_r[1:0];
				RSC_OFF_WDKEY: wdkey_r <= w_data_r[7:3];
				default: ;
			endcase
		end
	end

	// cause flags: only power-on clears them by hardware; set beats a software clear
	always_ff @(posedge aclk)
	begin
		if (!aresetn || por_event)
			cause_r <= 4'h0;
		else
		begin
			for (int i = 0; i < 4; i++)
			begin
				if (wr_lane && aw_addr_r == RSC_OFF_CAUSE && !w_data_r[i])
					cause_r[i] <= 1'b0;
			end
			if (st_r == RSC_FIRE)
			begin
				if (pend_r[2]) cause_r[RSC_B_GUARD] <= 1'b1;
				if (pend_r[1]) cause_r[RSC_B_THFLT] <= 1'b1;
				if (pend_r[0]) cause_r[RSC_B_WDCTL] <= 1'b1;
			end
			if (brown_fire)
				cause_r[RSC_B_BROWN] <= 1'b1;
		end
	end

	// time-out / power-down status and sleep mode control
	always_ff @(posedge aclk)
	begin
		if (!aresetn || por_event)
		begin
			to_r <= 1'b0;
			pdf_r <= 1'b0;
			sleep_r <= 1'b0;
		end
		else if (warm_rst)
		begin
			to_r <= 1'b1;
			pdf_r <= 1'b1;
		end
		else if (full_rst)
		begin
			if (wdt_timeout) to_r <= 1'b1;
			sleep_r <= 1'b0; // brownout keeps flags
		end
		else if (wr_lane && aw_addr_r == RSC_OFF_CTRL)
			sleep_r <= w_data_r[RSC_B_SLEEP];
	end

	// axi read path
	assign s_arready = !s_rvalid;
	assign ra = s_araddr[7:0];
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_rvalid <= 1'b0;
			s_rdata <= 32'h0;
			s_rresp <= RSC_RESP_OKAY;
		end
		else if (s_arvalid && s_arready)
		begin
			s_rvalid <= 1'b1;
			s_rresp <= RSC_RESP_OKAY;
			unique case (ra)
				RSC_OFF_GUARD: s_rdata <= {24'h0, guard_r};
				RSC_OFF_CAUSE: s_rdata <= {28'h0, cause_r};
				RSC_OFF_THRESH: s_rdata <= {24'h0, thresh_r};
				RSC_OFF_FILT: s_rdata <= {30'h0, filt_r};
				RSC_OFF_WDKEY: s_rdata <= {24'h0, wdkey_r, 3'b000};
				RSC_OFF_FLASH1: s_rdata <= 32'h0;
				RSC_OFF_STATUS: s_rdata <= {30'h0, pdf_r, to_r};
				RSC_OFF_CTRL: s_rdata <= {31'h0, sleep_r};
				default:
				begin
					s_rdata <= 32'h0;
					s_rresp <= RSC_RESP_SLVERR;
				end
			endcase
		end
		else if (s_rvalid && s_rready)
			s_rvalid <= 1'b0;
	end

	// checks
	a_guard_delay: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_r == RSC_RUN && guard_bad && !full_rst && !por_event) |=> st_r == RSC_DELAY)
		else $error("guard fault not caught");
	a_guard_flag: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_r == RSC_FIRE && pend_r[2] && !por_event) |=> cause_r[RSC_B_GUARD]) else $error("guard flag not set");
	// no flag that was set may drop across a reset that is not power-on
	a_cause_keep: assert property (@(posedge aclk) disable iff (!aresetn)
		(full_rst && !por_event && !wr_lane) |=> ($past(cause_r) & ~cause_r) == 4'h0)
		else $error("cause flags lost");
	a_brown_flag: assert property (@(posedge aclk) disable iff (!aresetn)
		(brown_fire && !por_event) |=> cause_r[RSC_B_BROWN]) else $error("brownout flag missing");
	// judged at the reset output, so a broken sleep gate cannot hide
	a_sleep_nolvr: assert property (@(posedge aclk) disable iff (!aresetn)
		(sleep_r && low_voltage && !por_event && !wdt_timeout && !flash_req && st_r != RSC_FIRE)
		|=> !chip_reset.full) else $error("brownout in sleep");
	a_warm_flags: assert property (@(posedge aclk) disable iff (!aresetn)
		(warm_rst && !por_event) |=> to_r && pdf_r && $stable(guard_r)) else $error("warm reset flags");
	a_flash_rst: assert property (@(posedge aclk) disable iff (!aresetn)
		flash_req |=> chip_reset.full) else $error("flash reset missing");
	a_thresh_keep: assert property (@(posedge aclk) disable iff (!aresetn)
		(brown_fire && !por_event && !thresh_bad) |=> $stable(thresh_r)) else $error("threshold reloaded");
	// fire is only reached from delay with the count at its end point
	a_delay_len: assert property (@(posedge aclk) disable iff (!aresetn)
		st_r == RSC_FIRE |-> $past(st_r) == RSC_DELAY && dly_r == 16'(SRESET_CYC - 1))
		else $error("delay skipped");
	c_guard_fire: cover property (@(posedge aclk) st_r == RSC_FIRE && pend_r[2]);
	c_brownout: cover property (@(posedge aclk) brown_fire);
	c_warm: cover property (@(posedge aclk) warm_rst);
endmodule

// File: core/rsc_pkg.sv
// package for the reset source controller: register map, codes, timing
package rsc_pkg;
	// register byte offsets (aligned words on the register bus)
	localparam logic [7:0] RSC_OFF_GUARD = 8'h00;
	localparam logic [7:0] RSC_OFF_CAUSE = 8'h04;
	localparam logic [7:0] RSC_OFF_THRESH = 8'h08;
	localparam logic [7:0] RSC_OFF_FILT = 8'h0c;
	localparam logic [7:0] RSC_OFF_WDKEY = 8'h10;
	localparam logic [7:0] RSC_OFF_FLASH1 = 8'h14;
	localparam logic [7:0] RSC_OFF_STATUS = 8'h18;
	localparam logic [7:0] RSC_OFF_CTRL = 8'h1c;
	// reset values
	localparam logic [7:0] RSC_GUARD_POR = 8'h55;
	localparam logic [7:0] RSC_GUARD_ALT = 8'haa;
	localparam logic [7:0] RSC_THRESH_POR = 8'h66;
	localparam logic [1:0] RSC_FILT_POR = 2'h1;
	localparam logic [4:0] RSC_WDKEY_POR = 5'h0a;
	localparam logic [4:0] RSC_WDKEY_OFF = 5'h15;
	// threshold codes
	localparam logic [7:0] RSC_TH_1V70 = 8'h66;
	localparam logic [7:0] RSC_TH_1V90 = 8'h55;
	localparam logic [7:0] RSC_TH_2V55 = 8'h33;
	localparam logic [7:0] RSC_TH_3V15 = 8'h99;
	localparam logic [7:0] RSC_TH_3V80 = 8'haa;
	localparam logic [7:0] RSC_TH_OFF = 8'hf0;
	localparam logic [7:0] RSC_FLASH_RST = 8'h55;
	// cause flag bit positions
	localparam int RSC_B_WDCTL = 0;
	localparam int RSC_B_THFLT = 1;
	localparam int RSC_B_BROWN = 2;
	localparam int RSC_B_GUARD = 3;
	// status / ctrl bit positions
	localparam int RSC_B_TO = 0;
	localparam int RSC_B_PDF = 1;
	localparam int RSC_B_SLEEP = 0;
	// filter widths in low-speed oscillator periods (upper bound of each pair)
	localparam logic [7:0] RSC_FW0 = 8'h08;
	localparam logic [7:0] RSC_FW1 = 8'h20;
	localparam logic [7:0] RSC_FW2 = 8'h40;
	localparam logic [7:0] RSC_FW3 = 8'h80;
	// timing
	localparam int RSC_CLK_MHZ = 25;
	localparam int RSC_SRESET_NS = 200;
	localparam int RSC_SRESET_CYC = (RSC_SRESET_NS * RSC_CLK_MHZ + 999) / 1000;
	localparam logic [1:0] RSC_RESP_OKAY = 2'b00;
	localparam logic [1:0] RSC_RESP_SLVERR = 2'b10;
	// reset request kinds sent to the rest of the chip
	typedef struct packed {
		logic full;   // whole-device reset
		logic warm;   // pc and stack pointer only
	} rsc_req_s;
	typedef enum logic [1:0] {
		RSC_RUN = 2'b00,
		RSC_DELAY = 2'b01,
		RSC_FIRE = 2'b10
	} rsc_state_e;
endpackage

// File: sim/rsc_top_tb.sv
// directed bench for the reset source controller
`timescale 1ns/1ps
module rsc_top_tb
	import rsc_pkg::*;
;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic por_event = 1'b0;
	logic low_voltage = 1'b0;
	logic low_speed_oscillator_tick = 1'b0;
	logic wdt_timeout = 1'b0;
	logic [31:0] awaddr = '0, wdata = '0, araddr = '0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [3:0] wstrb = 4'hf;
	logic awready, wready, bvalid, arready, rvalid, lvr_active;
	logic [1:0] bresp, rresp, rsp;
	logic [31:0] rdata, rd_d;
	rsc_req_s chip_reset;
	int n_mismatch = 0, tests_run = 0, n_full = 0, n_warm = 0;

	// 25 MHz clock
	always #20 aclk = ~aclk;

	// short soft reset delay keeps the runs brief
	rsc_top #(.SRESET_CYC(2)) i_rsc_top (.aclk(aclk), .aresetn(aresetn), .por_event(por_event),
		.low_voltage(low_voltage), .low_speed_oscillator_tick(low_speed_oscillator_tick), .wdt_timeout(wdt_timeout), .s_awaddr(awaddr),
		.s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata), .s_wstrb(wstrb), .s_wvalid(wvalid),
		.s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready), .s_araddr(araddr),
		.s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid),
		.s_rready(rready), .chip_reset(chip_reset), .lvr_active(lvr_active));

	// count reset pulses; one-cycle pulses would be missed by polling tasks
	always @(posedge aclk)
	begin
		n_full += (chip_reset.full === 1'b1);
		n_warm += (chip_reset.warm === 1'b1);
	end

	task automatic stop_test();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp)
		begin
			$display("Error %s expected %h seen %h", what, exp, got);
			n_mismatch++;
		end
	endtask

	// write: address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bit aw_ok, w_ok;
		aw_ok = 0;
		w_ok = 0;
		@(posedge aclk);
		awaddr <= {24'h0, a};
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_ok && w_ok))
		begin
			@(posedge aclk);
			aw_ok = aw_ok || (awready === 1'b1);
			w_ok = w_ok || (wready === 1'b1);
			awvalid <= !aw_ok;
			wvalid <= !w_ok;
		end
		do
			@(posedge aclk);
		while (bvalid !== 1'b1);
		rsp = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= {24'h0, a};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
			@(posedge aclk);
		while (arready !== 1'b1);
		arvalid <= 1'b0;
		do
			@(posedge aclk);
		while (rvalid !== 1'b1);
		rd_d = rdata;
		rsp = rresp;
		rready <= 1'b0;
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] e, input string what);
		rd(a);
		chk(what, e, rd_d);
	endtask

	// let any pending reset land, then compare pulse counts
	task automatic settle(input int f, input int w);
		repeat (30) @(posedge aclk);
		chk("full resets", f, n_full);
		chk("warm resets", w, n_warm);
		n_full = 0;
		n_warm = 0;
	endtask

	// low supply held for n low-speed periods, then released
	task automatic brown(input int n);
		@(posedge aclk);
		low_voltage <= 1'b1;
		repeat (n)
		begin
			@(posedge aclk);
			low_speed_oscillator_tick <= 1'b1;
			@(posedge aclk);
			low_speed_oscillator_tick <= 1'b0;
		end
		@(posedge aclk);
		low_voltage <= 1'b0;
	endtask

	task automatic pulse(input bit por);
		@(posedge aclk);
		if (por)
			por_event <= 1'b1;
		else
			wdt_timeout <= 1'b1;
		@(posedge aclk);
		por_event <= 1'b0;
		wdt_timeout <= 1'b0;
	endtask

	task automatic t_regs();
		n_full = 0;
		n_warm = 0;
		rc(RSC_OFF_GUARD, 8'h55, "guard");
		rc(RSC_OFF_THRESH, 8'h66, "threshold");
		rc(RSC_OFF_FILT, 8'h01, "filter");
		rc(RSC_OFF_CAUSE, 8'h00, "cause");
		rc(RSC_OFF_STATUS, 8'h00, "status");
		rc(8'h20, 8'h00, "unmapped data");
		chk("unmapped rresp", RSC_RESP_SLVERR, rsp);
		wr(8'h20, 8'h12);
		chk("unmapped bresp", RSC_RESP_SLVERR, rsp);
		chk("lvr armed", 1, lvr_active);
		$display("done regs");
	endtask

	task automatic t_guard();
		wr(RSC_OFF_GUARD, RSC_GUARD_ALT);
		chk("bresp", RSC_RESP_OKAY, rsp);
		settle(0, 0);
		wr(RSC_OFF_GUARD, 8'h12);
		settle(1, 0);
		rc(RSC_OFF_CAUSE, 8'h08, "cause");
		rc(RSC_OFF_GUARD, 8'h55, "guard");
		$display("done guard");
	endtask

	task automatic t_thresh();
		logic [7:0] codes [5] = '{8'h66, 8'h55, 8'h33, 8'h99, 8'haa};
		foreach (codes[i])
		begin
			wr(RSC_OFF_THRESH, codes[i]);
			settle(0, 0);
			chk("lvr armed", 1, lvr_active);
		end
		wr(RSC_OFF_THRESH, RSC_TH_OFF);
		chk("lvr armed", 0, lvr_active);
		brown(10);
		settle(0, 0);
		wr(RSC_OFF_THRESH, 8'h12);
		settle(1, 0);
		rc(RSC_OFF_CAUSE, 8'h0a, "cause");
		rc(RSC_OFF_THRESH, 8'h66, "threshold");
		$display("done threshold");
	endtask

	task automatic t_brown();
		wr(RSC_OFF_THRESH, RSC_TH_2V55);
		wr(RSC_OFF_FILT, 8'h00);
		brown(6);
		settle(0, 0);
		brown(10);
		settle(1, 0);
		rc(RSC_OFF_CAUSE, 8'h0e, "cause");
		rc(RSC_OFF_THRESH, 8'h33, "threshold");
		rc(RSC_OFF_FILT, 8'h01, "filter");
		brown(30);
		settle(0, 0);
		brown(34);
		settle(1, 0);
		wr(RSC_OFF_FILT, 8'h02);
		rc(RSC_OFF_FILT, 8'h02, "filter");
		brown(62);
		settle(0, 0);
		brown(66);
		settle(1, 0);
		wr(RSC_OFF_FILT, 8'h03);
		brown(126);
		settle(0, 0);
		brown(130);
		settle(1, 0);
		rc(RSC_OFF_STATUS, 8'h00, "status");
		$display("done brownout");
	endtask

	task automatic t_key();
		wr(RSC_OFF_WDKEY, 8'h00);
		settle(1, 0);
		rc(RSC_OFF_CAUSE, 8'h0f, "cause");
		wr(RSC_OFF_CAUSE, 8'hff);
		rc(RSC_OFF_CAUSE, 8'h0f, "cause");
		wr(RSC_OFF_CAUSE, 8'h00);
		rc(RSC_OFF_CAUSE, 8'h00, "cause");
		wr(RSC_OFF_WDKEY, {RSC_WDKEY_OFF, 3'b000});
		settle(0, 0);
		wr(RSC_OFF_FLASH1, 8'h54);
		settle(0, 0);
		wr(RSC_OFF_FLASH1, RSC_FLASH_RST);
		settle(1, 0);
		$display("done key");
	endtask

	task automatic t_wdt();
		pulse(0);
		settle(1, 0);
		rc(RSC_OFF_STATUS, 8'h01, "status");
		// a brownout must leave the time-out flag as it stands
		brown(40);
		settle(1, 0);
		rc(RSC_OFF_STATUS, 8'h01, "status");
		wr(RSC_OFF_GUARD, RSC_GUARD_ALT);
		wr(RSC_OFF_CTRL, 8'h01);
		chk("lvr armed", 0, lvr_active);
		brown(40);
		pulse(0);
		settle(0, 1);
		rc(RSC_OFF_STATUS, 8'h03, "status");
		rc(RSC_OFF_GUARD, 8'haa, "guard");
		wr(RSC_OFF_CTRL, 8'h00);
		brown(40);
		settle(1, 0);
		rc(RSC_OFF_STATUS, 8'h03, "status");
		wr(RSC_OFF_GUARD, 8'h12);
		settle(1, 0);
		pulse(1);
		settle(1, 0);
		rc(RSC_OFF_CAUSE, 8'h00, "cause");
		rc(RSC_OFF_STATUS, 8'h00, "status");
		rc(RSC_OFF_GUARD, 8'h55, "guard");
		$display("done watchdog");
	endtask

	// main sequence
	initial
	begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_guard();
		t_thresh();
		t_brown();
		t_key();
		t_wdt();
		stop_test();
	end

	// hang guard, well past the few thousand cycles the tests need
	initial
	begin
		#(40 * 20000);
		n_mismatch++;
		stop_test();
	end
endmodule
